// File: src/sec_pkg.sv
// Constants shared by the serial non-volatile memory controller.
`default_nettype none
package sec_pkg;
    // Host command codes carried in the op code field.
    localparam logic [2:0] OP_READ   = 3'h0;
    localparam logic [2:0] OP_WRITE_DISABLE_CMD   = 3'h1;
    localparam logic [2:0] OP_WRITE_ENABLE_CMD   = 3'h2;
    localparam logic [2:0] OP_WRITE  = 3'h3;
    localparam logic [2:0] OP_WRITE_ALL_CMD   = 3'h4;
    localparam logic [2:0] OP_ERASE  = 3'h5;
    localparam logic [2:0] OP_ERASE_ALL_CMD   = 3'h6;
    localparam logic [2:0] OP_RELOAD = 3'h7;

    // Serial opcodes and fixed address patterns of the three-wire memory.
    localparam logic [1:0] MW_READ   = 2'h2;
    localparam logic [1:0] MW_WRITE  = 2'h1;
    localparam logic [1:0] MW_ERASE  = 2'h3;
    localparam logic [1:0] MW_SPEC   = 2'h0;
    localparam logic [6:0] AD_WRITE_ENABLE_CMD   = 7'h60;
    localparam logic [6:0] AD_WRITE_DISABLE_CMD   = 7'h00;
    localparam logic [6:0] AD_ERASE_ALL_CMD   = 7'h40;
    localparam logic [6:0] AD_WRITE_ALL_CMD   = 7'h20;

    // Frame geometry: 128 locations of 8 bits.
    localparam int unsigned LOC_W    = 7;
    localparam int unsigned FRAME_W  = 18;
    localparam logic [4:0]  NB_SHORT = 5'h0A;
    localparam logic [4:0]  NB_LONG  = 5'h12;
    localparam logic [4:0]  RD_FIRST = 5'h0A;

    // Auto-load signature, its location and the station address length.
    localparam logic [7:0] SIG_VALUE = 8'hA5;
    localparam logic [6:0] SIG_LOC   = 7'h00;
    localparam logic [2:0] LAST_IDX  = 3'h6;

    // Response timeout: 30 ms at the 125 MHz system clock.
    localparam int unsigned TO_TIME_MS  = 30;
    localparam int unsigned SYS_CLK_KHZ = 125000;
    localparam int unsigned TO_CYC      = TO_TIME_MS * SYS_CLK_KHZ;
    localparam int unsigned TMR_W       = 22;

    // Half period of the serial clock in link clock cycles.
    localparam int unsigned HALF_DIV = 8;

    typedef enum logic [1:0] {
        S_IDLE  = 2'b00,
        S_ISSUE = 2'b01,
        S_WAIT  = 2'b10
    } sec_sys_state_t;

    typedef enum logic [2:0] {
        L_IDLE  = 3'b000,
        L_SHIFT = 3'b001,
        L_GAP   = 3'b010,
        L_POLL  = 3'b011,
        L_DONE  = 3'b100
    } sec_link_state_t;
endpackage
`default_nettype wire

// File: src/sec_ctrl.sv
// Serial non-volatile memory controller: auto-load, host commands, serial engine.
`default_nettype none
// Functional notes
// - After reset read location 0, expect A5h.
// - Six following bytes fill station address, low first.
// - Loaded flag only after all six bytes.
// - Bad signature ends load, address untouched.
// - Reload repeats check and load, fails cleanly.
// - Memory is 128 x 8, three-wire protocol.
// - Busy bit starts command, cleared at completion.
// - Read data is in data register at completion.
// - No response in 30 ms sets timeout.
// - Disabled interface frees pins for outputs/monitors.
// - Op code selects one of eight operations.
// - Frames are 10 or 18 serial clocks.
// - Successful reload sets load-complete flag.
module sec_ctrl #(
    parameter int unsigned P_TIMEOUT_CYC = sec_pkg::TO_CYC,
    parameter int unsigned P_HALF_DIV    = sec_pkg::HALF_DIV
) (
    // System clock and reset.
    input  wire logic        i_sys_clk,
    input  wire logic        i_srst,
    // Serial link clock.
    input  wire logic        i_link_clk,
    // Host command register write.
    input  wire logic        i_cmd_wr,
    input  wire logic        i_cmd_busy,
    input  wire logic [2:0]  i_cmd_op,
    input  wire logic [6:0]  i_cmd_loc,
    // Host data register write.
    input  wire logic        i_data_wr,
    input  wire logic [7:0]  i_data_wdata,
    // Command and data register readback.
    output logic             o_nvm_busy_flag,
    output logic             o_nvm_timeout_flag,
    output logic             o_nvm_load_ok_flag,
    output logic             o_mac_loaded_flag,
    output logic [2:0]       o_nvm_op_code,
    output logic [6:0]       o_nvm_location,
    output logic [7:0]       o_nvm_data_reg,
    // Station address.
    output logic [31:0]      o_station_addr_low,
    output logic [15:0]      o_station_addr_high,
    // Pin sharing configuration.
    input  wire logic        i_nvm_if_disable,
    input  wire logic        i_gp_mon_sel,
    input  wire logic [1:0]  i_gp_out,
    input  wire logic [1:0]  i_mon_sig,
    // Serial memory pins.
    output logic             o_nvm_cs,
    output logic             o_nvm_serial_clock_pin,
    output logic             o_nvm_serial_data_pin_o,
    output logic             o_nvm_serial_data_pin_oe,
    input  wire logic        i_nvm_serial_data_pin
);
    localparam logic [sec_pkg::TMR_W-1:0] TO_LAST = sec_pkg::TMR_W'(P_TIMEOUT_CYC - 1);
    localparam logic [7:0] HALF_LAST = 8'(P_HALF_DIV - 1);

    // Maps a host op code to serial opcode, address, length and ready polling.
    function automatic logic [14:0] sec_map(input logic [2:0] op, input logic [6:0] loc);
        logic [14:0] r;
        r = {sec_pkg::MW_READ, loc, sec_pkg::NB_LONG, 1'b0};
        case (op)
            sec_pkg::OP_WRITE_DISABLE_CMD:  r = {sec_pkg::MW_SPEC, sec_pkg::AD_WRITE_DISABLE_CMD, sec_pkg::NB_SHORT, 1'b0};
            sec_pkg::OP_WRITE_ENABLE_CMD:  r = {sec_pkg::MW_SPEC, sec_pkg::AD_WRITE_ENABLE_CMD, sec_pkg::NB_SHORT, 1'b0};
            sec_pkg::OP_ERASE: r = {sec_pkg::MW_ERASE, loc, sec_pkg::NB_SHORT, 1'b1};
            sec_pkg::OP_ERASE_ALL_CMD:  r = {sec_pkg::MW_SPEC, sec_pkg::AD_ERASE_ALL_CMD, sec_pkg::NB_SHORT, 1'b1};
            sec_pkg::OP_WRITE: r = {sec_pkg::MW_WRITE, loc, sec_pkg::NB_LONG, 1'b1};
            sec_pkg::OP_WRITE_ALL_CMD:  r = {sec_pkg::MW_SPEC, sec_pkg::AD_WRITE_ALL_CMD, sec_pkg::NB_LONG, 1'b1};
            default:           r = {sec_pkg::MW_READ, loc, sec_pkg::NB_LONG, 1'b0};
        endcase
        return r;
    endfunction

    sec_pkg::sec_sys_state_t  s_state_r;
    sec_pkg::sec_link_state_t l_state_r;
    logic                     busy_r, to_r, load_ok_r, mac_loaded_r, load_r, reload_r;
    logic                     abort_r, req_t_r;
    logic [2:0]               idx_r, cmd_op_r, req_code_r;
    logic [6:0]               cmd_loc_r, req_loc_r;
    logic [7:0]               data_r;
    logic [47:0]              station_r;
    logic [sec_pkg::TMR_W-1:0] timer_r;
    logic                     done_s1_r, done_s2_r, done_s3_r;
    logic                     done_evt;
    // Link side.
    logic                     lrst_s1_r, lrst_r;
    logic                     req_s1_r, req_s2_r, req_seen_r, done_t_r;
    logic                     ab_s1_r, ab_s2_r, din_s1_r, din_s2_r;
    logic [5:0]               cfg_s1_r, cfg_s2_r;
    logic                     cs_r, sclk_r, dout_r, oe_r, poll_r, rd_r;
    logic [7:0]               div_r;
    logic [4:0]               bit_cnt_r, nbits_r;
    logic [sec_pkg::FRAME_W-1:0] sh_r;
    logic [7:0]               rx_r;
    logic [14:0]              map_w;

    // Completion toggle from the link; only the second and third stages feed logic.
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            done_s1_r <= 1'b0;
            done_s2_r <= 1'b0;
            done_s3_r <= 1'b0;
        end else begin
            done_s1_r <= done_t_r;
            done_s2_r <= done_s1_r;
            done_s3_r <= done_s2_r;
        end
    end
    assign done_evt = done_s2_r ^ done_s3_r;

    // Command sequencer; reset starts the auto-load with busy already set.
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            s_state_r    <= sec_pkg::S_ISSUE;
            busy_r       <= 1'b1;
            load_r       <= 1'b1;
            reload_r     <= 1'b0;
            idx_r        <= 3'h0;
            mac_loaded_r <= 1'b0;
            load_ok_r    <= 1'b0;
            to_r         <= 1'b0;
            abort_r      <= 1'b0;
            timer_r      <= '0;
            req_t_r      <= 1'b0;
            req_code_r   <= sec_pkg::OP_READ;
            req_loc_r    <= sec_pkg::SIG_LOC;
            cmd_op_r     <= sec_pkg::OP_READ;
            cmd_loc_r    <= 7'h00;
            data_r       <= 8'h00;
            station_r    <= 48'h000000000000;
        end else begin
            case (s_state_r)
                sec_pkg::S_IDLE: begin
                    // Writes while busy are dropped; the host must poll busy first.
                    if (i_data_wr) begin
                        data_r <= i_data_wdata;
                    end
                    if (i_cmd_wr) begin
                        cmd_op_r  <= i_cmd_op;
                        cmd_loc_r <= i_cmd_loc;
                        if (i_cmd_busy) begin
                            busy_r    <= 1'b1;
                            to_r      <= 1'b0;
                            s_state_r <= sec_pkg::S_ISSUE;
                            if (i_cmd_op == sec_pkg::OP_RELOAD) begin
                                load_r       <= 1'b1;
                                reload_r     <= 1'b1;
                                idx_r        <= 3'h0;
                                mac_loaded_r <= 1'b0;
                                load_ok_r    <= 1'b0;
                            end
                        end
                    end
                end
                sec_pkg::S_ISSUE: begin
                    req_code_r <= load_r ? sec_pkg::OP_READ : cmd_op_r;
                    req_loc_r  <= load_r ? {4'h0, idx_r} : cmd_loc_r;
                    req_t_r    <= ~req_t_r;
                    timer_r    <= '0;
                    s_state_r  <= sec_pkg::S_WAIT;
                end
                sec_pkg::S_WAIT: begin
                    if (done_evt) begin
                        abort_r <= 1'b0;
                        if (abort_r) begin
                            busy_r    <= 1'b0;
                            load_r    <= 1'b0;
                            reload_r  <= 1'b0;
                            s_state_r <= sec_pkg::S_IDLE;
                        end else if (load_r && idx_r == 3'h0) begin
                            if (rx_r != sec_pkg::SIG_VALUE) begin
                                busy_r    <= 1'b0;
                                load_r    <= 1'b0;
                                reload_r  <= 1'b0;
                                s_state_r <= sec_pkg::S_IDLE;
                            end else begin
                                idx_r     <= 3'h1;
                                s_state_r <= sec_pkg::S_ISSUE;
                            end
                        end else if (load_r) begin
                            station_r[{idx_r - 3'h1, 3'h0} +: 8] <= rx_r;
                            if (idx_r == sec_pkg::LAST_IDX) begin
                                mac_loaded_r <= 1'b1;
                                load_ok_r    <= reload_r;
                                busy_r       <= 1'b0;
                                load_r       <= 1'b0;
                                reload_r     <= 1'b0;
                                s_state_r    <= sec_pkg::S_IDLE;
                            end else begin
                                idx_r     <= idx_r + 3'h1;
                                s_state_r <= sec_pkg::S_ISSUE;
                            end
                        end else begin
                            if (cmd_op_r == sec_pkg::OP_READ) begin
                                data_r <= rx_r;
                            end
                            busy_r    <= 1'b0;
                            s_state_r <= sec_pkg::S_IDLE;
                        end
                    end else if (!abort_r) begin
                        // The abort waits for the link to close the frame first.
                        if (timer_r == TO_LAST) begin
                            to_r    <= 1'b1;
                            abort_r <= 1'b1;
                        end else begin
                            timer_r <= timer_r + 1'b1;
                        end
                    end
                end
                default: s_state_r <= sec_pkg::S_IDLE;
            endcase
        end
    end

    assign o_nvm_busy_flag     = busy_r;
    assign o_nvm_timeout_flag  = to_r;
    assign o_nvm_load_ok_flag  = load_ok_r;
    assign o_mac_loaded_flag   = mac_loaded_r;
    assign o_nvm_op_code       = cmd_op_r;
    assign o_nvm_location      = cmd_loc_r;
    assign o_nvm_data_reg      = data_r;
    assign o_station_addr_low  = station_r[31:0];
    assign o_station_addr_high = station_r[47:32];

    // Link-side synchronisers for reset, request, abort, pin data and pin config.
    always_ff @(posedge i_link_clk) begin
        lrst_s1_r <= i_srst;
        lrst_r    <= lrst_s1_r;
        req_s1_r  <= req_t_r;
        req_s2_r  <= req_s1_r;
        ab_s1_r   <= abort_r;
        ab_s2_r   <= ab_s1_r;
        din_s1_r  <= i_nvm_serial_data_pin;
        din_s2_r  <= din_s1_r;
        // Raw bits only; the selection is made after the second stage.
        cfg_s1_r  <= {i_nvm_if_disable, i_gp_mon_sel, i_mon_sig, i_gp_out};
        cfg_s2_r  <= cfg_s1_r;
    end

    // Request words are held stable by the sequencer while a request is open.
    assign map_w = sec_map(req_code_r, req_loc_r);

    // Serial engine: start bit, opcode, 7-bit location, optional data byte.
    always_ff @(posedge i_link_clk) begin
        if (lrst_r) begin
            l_state_r  <= sec_pkg::L_IDLE;
            req_seen_r <= 1'b0;
            done_t_r   <= 1'b0;
            cs_r       <= 1'b0;
            sclk_r     <= 1'b0;
            dout_r     <= 1'b0;
            oe_r       <= 1'b0;
            poll_r     <= 1'b0;
            rd_r       <= 1'b0;
            div_r      <= 8'h00;
            bit_cnt_r  <= 5'h00;
            nbits_r    <= 5'h00;
            sh_r       <= '0;
            rx_r       <= 8'h00;
        end else begin
            case (l_state_r)
                sec_pkg::L_IDLE: begin
                    if (req_s2_r != req_seen_r) begin
                        req_seen_r <= req_s2_r;
                        sh_r       <= {1'b1, map_w[14:6], data_r};
                        nbits_r    <= map_w[5:1];
                        poll_r     <= map_w[0];
                        rd_r       <= (map_w[14:13] == sec_pkg::MW_READ);
                        cs_r       <= 1'b1;
                        dout_r     <= 1'b1;
                        oe_r       <= 1'b1;
                        sclk_r     <= 1'b0;
                        div_r      <= 8'h00;
                        bit_cnt_r  <= 5'h00;
                        l_state_r  <= sec_pkg::L_SHIFT;
                    end
                end
                sec_pkg::L_SHIFT: begin
                    if (ab_s2_r) begin
                        cs_r      <= 1'b0;
                        sclk_r    <= 1'b0;
                        oe_r      <= 1'b0;
                        l_state_r <= sec_pkg::L_DONE;
                    end else if (div_r == HALF_LAST) begin
                        div_r <= 8'h00;
                        if (!sclk_r) begin
                            sclk_r <= 1'b1;
                        end else begin
                            // Sampling at the falling edge leaves a half period
                            // for the memory output and the two sync stages.
                            sclk_r    <= 1'b0;
                            rx_r      <= {rx_r[6:0], din_s2_r};
                            bit_cnt_r <= bit_cnt_r + 5'h01;
                            sh_r      <= {sh_r[sec_pkg::FRAME_W-2:0], 1'b0};
                            dout_r    <= sh_r[sec_pkg::FRAME_W-2];
                            oe_r      <= !(rd_r && (bit_cnt_r + 5'h01 >= sec_pkg::RD_FIRST));
                            if (bit_cnt_r == nbits_r - 5'h01) begin
                                cs_r      <= 1'b0;
                                oe_r      <= 1'b0;
                                l_state_r <= poll_r ? sec_pkg::L_GAP : sec_pkg::L_DONE;
                            end
                        end
                    end else begin
                        div_r <= div_r + 8'h01;
                    end
                end
                sec_pkg::L_GAP: begin
                    // Chip select low for one half period before the ready poll.
                    if (div_r == HALF_LAST) begin
                        cs_r      <= 1'b1;
                        l_state_r <= sec_pkg::L_POLL;
                    end else begin
                        div_r <= div_r + 8'h01;
                    end
                end
                sec_pkg::L_POLL: begin
                    if (ab_s2_r || din_s2_r) begin
                        cs_r      <= 1'b0;
                        l_state_r <= sec_pkg::L_DONE;
                    end
                end
                sec_pkg::L_DONE: begin
                    done_t_r  <= ~done_t_r;
                    l_state_r <= sec_pkg::L_IDLE;
                end
                default: l_state_r <= sec_pkg::L_IDLE;
            endcase
        end
    end

    // Pin mux; when disabled the pins carry general outputs or monitors.
    always_ff @(posedge i_link_clk) begin
        if (lrst_r) begin
            o_nvm_cs                 <= 1'b0;
            o_nvm_serial_clock_pin   <= 1'b0;
            o_nvm_serial_data_pin_o  <= 1'b0;
            o_nvm_serial_data_pin_oe <= 1'b0;
        end else if (cfg_s2_r[5]) begin
            o_nvm_cs                 <= 1'b0;
            o_nvm_serial_clock_pin   <= cfg_s2_r[4] ? cfg_s2_r[3] : cfg_s2_r[1];
            o_nvm_serial_data_pin_o  <= cfg_s2_r[4] ? cfg_s2_r[2] : cfg_s2_r[0];
            o_nvm_serial_data_pin_oe <= 1'b1;
        end else begin
            o_nvm_cs                 <= cs_r;
            o_nvm_serial_clock_pin   <= sclk_r;
            o_nvm_serial_data_pin_o  <= dout_r;
            o_nvm_serial_data_pin_oe <= oe_r;
        end
    end

    // Count of serial clocks in the current frame, for checking only.
    logic [4:0] rise_cnt_r;
    always_ff @(posedge i_link_clk) begin
        if (lrst_r || l_state_r == sec_pkg::L_IDLE) begin
            rise_cnt_r <= 5'h00;
        end else if (l_state_r == sec_pkg::L_SHIFT && div_r == HALF_LAST && !sclk_r) begin
            rise_cnt_r <= rise_cnt_r + 5'h01;
        end
    end

    chk_reset_busy: assert property (@(posedge i_sys_clk)
        i_srst ##1 !i_srst |-> busy_r && load_r)
        else $error("busy not set during auto-load");
    chk_sig_accept: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        s_state_r == sec_pkg::S_WAIT && done_evt && !abort_r && load_r && idx_r == 3'h0
        && rx_r == sec_pkg::SIG_VALUE |=> idx_r == 3'h1 ##1 req_loc_r == 7'h01)
        else $error("signature did not advance load");
    chk_byte_place: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        s_state_r == sec_pkg::S_WAIT && done_evt && !abort_r && load_r && idx_r != 3'h0
        |=> station_r[{$past(idx_r) - 3'h1, 3'h0} +: 8] == $past(rx_r))
        else $error("address byte misplaced");
    chk_loaded_six: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        $rose(mac_loaded_r) |-> $past(idx_r) == sec_pkg::LAST_IDX && !busy_r)
        else $error("loaded flag before six bytes");
    chk_bad_sig: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        s_state_r == sec_pkg::S_WAIT && done_evt && !abort_r && load_r && idx_r == 3'h0
        && rx_r != sec_pkg::SIG_VALUE |=> !busy_r && !mac_loaded_r && $stable(station_r))
        else $error("bad signature not handled");
    chk_read_data: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        $fell(busy_r) && !load_r && !$past(load_r) && !$past(abort_r)
        && cmd_op_r == sec_pkg::OP_READ |-> data_r == rx_r)
        else $error("read data missing at completion");
    chk_timeout_set: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        s_state_r == sec_pkg::S_WAIT && !done_evt && !abort_r && timer_r == TO_LAST
        |=> to_r && abort_r)
        else $error("timeout not flagged");
    chk_load_ok: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        $rose(load_ok_r) |-> $rose(mac_loaded_r) && $past(reload_r))
        else $error("load-complete without reload");
    chk_frame_len: assert property (@(posedge i_link_clk) disable iff (lrst_r)
        $past(l_state_r) == sec_pkg::L_SHIFT && $fell(cs_r) && !$past(ab_s2_r)
        |-> rise_cnt_r == nbits_r)
        else $error("wrong serial clock count");
    chk_start_bit: assert property (@(posedge i_link_clk) disable iff (lrst_r)
        $rose(cs_r) && l_state_r == sec_pkg::L_SHIFT |-> dout_r && oe_r && !sclk_r)
        else $error("frame did not open with start bit");
    chk_pin_gpio: assert property (@(posedge i_link_clk) disable iff (lrst_r)
        cfg_s2_r[5] |=> !o_nvm_cs && o_nvm_serial_data_pin_oe
        && o_nvm_serial_data_pin_o == $past(cfg_s2_r[4] ? cfg_s2_r[2] : cfg_s2_r[0]))
        else $error("pins not released to general use");

    cov_autoload_ok: cover property (@(posedge i_sys_clk) disable iff (i_srst)
        $rose(mac_loaded_r));
    cov_timeout: cover property (@(posedge i_sys_clk) disable iff (i_srst) $rose(to_r));
    cov_read_done: cover property (@(posedge i_sys_clk) disable iff (i_srst)
        $fell(busy_r) && cmd_op_r == sec_pkg::OP_READ && !load_r);
    cov_reload_ok: cover property (@(posedge i_sys_clk) disable iff (i_srst) $rose(load_ok_r));
endmodule
`default_nettype wire

// File: testbench/sec_mem_model.sv
// Behavioural model of the three-wire serial memory on the far side.
`default_nettype none
module sec_mem_model (
    input  wire logic i_cs,
    input  wire logic i_sclk,
    input  wire logic i_di,
    input  wire logic i_stall,
    output logic      o_do
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0]  mem [128];
    logic [17:0] sr;
    logic [7:0]  rd_byte;
    logic        rd = 0;
    logic        we = 0;
    int          cnt = 0;
    // Start with a signature and address bytes 11h..66h.
    initial begin
        for (int i = 0; i < 128; i++) mem[i] = 8'(i * 17);
        mem[0] = 8'hA5;
    end
    // Bits are taken on rising serial clock edges while selected.
    always @(posedge i_sclk or negedge i_cs) begin
        if (!i_cs) begin
            cnt = 0;
            rd = 0;
        end else begin
            cnt = cnt + 1;
            sr = {sr[16:0], i_di};
            if (cnt == 10 && sr[9:5] == 5'h13) we = 1;
            if (cnt == 10 && sr[9:5] == 5'h10) we = 0;
            if (cnt == 10 && sr[9:7] == 3'h6) begin
                rd = 1;
                rd_byte = mem[sr[6:0]];
            end
            if (cnt == 18 && we && sr[17:15] == 3'h5) mem[sr[14:8]] = sr[7:0];
            if (cnt == 10 && we && sr[9:7] == 3'h7) mem[sr[6:0]] = 8'hFF;
            if (cnt == 10 && we && sr[9:5] == 5'h12) foreach (mem[i]) mem[i] = 8'hFF;
            if (cnt == 18 && we && sr[17:13] == 5'h11) foreach (mem[i]) mem[i] = sr[7:0];
        end
    end
    // Read bits go out MSB first; otherwise the line shows ready unless stalled.
    assign o_do = (rd && cnt > 10) ? rd_byte[3'(18 - cnt)] : !i_stall;
endmodule
`default_nettype wire

// File: testbench/testbench.sv
// Self-checking bench for the serial memory controller.
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, lclk = 0, srst = 1, cwr = 0, cbusy = 0, dwr = 0, dis = 0, stall = 0;
    logic [2:0] op = 0;
    logic [6:0] loc = 0;
    logic [7:0] wd = 0;
    logic [1:0] gpo = 0;
    logic gmon = 0;
    logic [2:0] opc;
    logic [6:0] locr;
    logic busy, tof, lok, mld, cs, sclk, dout, doe, mdo, pin;
    logic [31:0] sal;
    logic [15:0] sah;
    logic [7:0] dreg;
    int bad_count = 0, check_count = 0;
    // Clocks: the link clock is offset so the two never line up.
    always #4 clk = ~clk;
    initial begin #1.7; forever #3 lclk = ~lclk; end
    // The data wire follows whoever drives it.
    assign pin = doe ? dout : mdo;
    sec_ctrl #(.P_TIMEOUT_CYC(2000), .P_HALF_DIV(4)) i_dut (.i_sys_clk(clk), .i_srst(srst),
        .i_link_clk(lclk), .i_cmd_wr(cwr), .i_cmd_busy(cbusy), .i_cmd_op(op), .i_cmd_loc(loc),
        .i_data_wr(dwr), .i_data_wdata(wd), .o_nvm_busy_flag(busy), .o_nvm_timeout_flag(tof),
        .o_nvm_load_ok_flag(lok), .o_mac_loaded_flag(mld), .o_nvm_op_code(opc),
        .o_nvm_location(locr), .o_nvm_data_reg(dreg), .o_station_addr_low(sal),
        .o_station_addr_high(sah), .i_nvm_if_disable(dis), .i_gp_mon_sel(gmon),
        .i_gp_out(gpo), .i_mon_sig(2'b01), .o_nvm_cs(cs), .o_nvm_serial_clock_pin(sclk),
        .o_nvm_serial_data_pin_o(dout), .o_nvm_serial_data_pin_oe(doe),
        .i_nvm_serial_data_pin(pin));
    sec_mem_model i_mem (.i_cs(cs), .i_sclk(sclk), .i_di(pin), .i_stall(stall), .o_do(mdo));
    task automatic check(string name, logic [47:0] seen, logic [47:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Bounded wait for the busy flag to drop; a hang counts as an error.
    task automatic wait_idle();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 5000) begin @(posedge clk); #1; n++; end
        check("busy_clear", busy, 1'b0);
    endtask
    // Data first, then the command with busy set, as the host must.
    task automatic cmd(logic [2:0] o, logic [6:0] l, logic [7:0] d);
        @(posedge clk) #1 dwr = 1; wd = d;
        @(posedge clk) #1 dwr = 0; cwr = 1; cbusy = 1; op = o; loc = l;
        @(posedge clk) #1 cwr = 0; cbusy = 0;
        wait_idle();
    endtask
    // Watchdog sized well beyond the expected run.
    initial begin #400000; bad_count++; end_of_test(); end
    initial begin
        repeat (5) @(posedge clk);
        check("busy_in_reset", busy, 1);
        #1 srst = 0;
        wait_idle();
        check("mac_loaded", mld, 1);
        check("station", {sah, sal}, 48'h665544332211);
        cmd(sec_pkg::OP_READ, 7'h03, 0);
        check("read_loc3", dreg, 8'h33);
        check("cmd_readback", {opc, locr}, {3'h0, 7'h03});
        cmd(sec_pkg::OP_WRITE_DISABLE_CMD, 0, 0);
        cmd(sec_pkg::OP_WRITE, 0, 8'h5A);
        cmd(sec_pkg::OP_READ, 0, 0);
        check("locked_write", dreg, 8'hA5);
        cmd(sec_pkg::OP_WRITE_ENABLE_CMD, 0, 0);
        cmd(sec_pkg::OP_WRITE, 0, 8'h5A);
        cmd(sec_pkg::OP_READ, 0, 0);
        check("read_back", dreg, 8'h5A);
        cmd(sec_pkg::OP_RELOAD, 0, 0);
        check("reload_bad", {lok, mld}, 0);
        check("station_kept", {sah, sal}, 48'h665544332211);
        cmd(sec_pkg::OP_WRITE, 7'h01, 8'h77);
        cmd(sec_pkg::OP_WRITE, 0, 8'hA5);
        cmd(sec_pkg::OP_RELOAD, 0, 0);
        check("reload_ok", {lok, mld}, 3);
        check("station_new", {sah, sal}, 48'h665544332277);
        cmd(sec_pkg::OP_WRITE_ALL_CMD, 0, 8'h3C);
        cmd(sec_pkg::OP_ERASE, 7'h05, 0);
        cmd(sec_pkg::OP_READ, 7'h06, 0);
        check("write_all", dreg, 8'h3C);
        cmd(sec_pkg::OP_READ, 7'h05, 0);
        check("erase_loc", dreg, 8'hFF);
        cmd(sec_pkg::OP_ERASE_ALL_CMD, 0, 0);
        cmd(sec_pkg::OP_READ, 7'h06, 0);
        check("erase_all", dreg, 8'hFF);
        stall = 1;
        cmd(sec_pkg::OP_ERASE, 1, 0);
        check("timeout", tof, 1);
        dis = 1;
        gpo = 2'b10;
        repeat (10) @(posedge clk);
        check("gp_pins", {sclk, pin}, 2'b10);
        gmon = 1;
        repeat (10) @(posedge clk);
        check("mon_pins", {sclk, pin}, 2'b01);
        end_of_test();
    end
endmodule
`default_nettype wire
